//--- logic/pdct_pkg.sv
// Package for the prescaled down-counter timer: offsets, fields, reset values
package pdct_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;

  // Control register field positions
  localparam int unsigned BIT_REQ_FLAG = 7;
  localparam int unsigned BIT_REQ_MASK = 6;
  localparam int unsigned BIT_SRC_SEL = 5;
  localparam int unsigned BIT_PIN_EN = 4;
  localparam int unsigned BIT_PSC_CLR = 3;
  localparam int unsigned BIT_PS_LSB = 0;
  localparam int unsigned PS_W = 3;

  // Option byte field position selecting option-controlled mode
  localparam int unsigned BIT_OPT_MODE = 6;

  // Widths and reset values
  localparam int unsigned CNT_W = 8;
  localparam int unsigned PRE_W = 7;
  localparam logic [7:0] CNT_RESET = 8'hff;
  localparam logic [6:0] PRE_RESET = 7'h7f;
  localparam logic [6:0] PRE_CLEAR = 7'h7f;
  localparam logic REQ_FLAG_RESET = 1'b0;
  localparam logic REQ_MASK_RESET = 1'b1;

  // Pin path: two synchroniser stages plus one edge stage
  localparam int unsigned PIN_SYNC_CYCLES = 3;

  // Clock source modes from {clock_source_select, input_pin_enable}
  typedef enum logic [1:0] {
    PDCT_SRC_INTERNAL = 2'b00,
    PDCT_SRC_GATED = 2'b01,
    PDCT_SRC_OFF = 2'b10,
    PDCT_SRC_EXTERNAL = 2'b11
  } pdct_src_t;

  // Software-visible configuration fields of the control register
  typedef struct packed {
    logic clock_source_select;
    logic input_pin_enable;
    logic [2:0] prescale_select;
  } pdct_cfg_t;
endpackage

//--- logic/pdct_timer.sv
// Prescaled 8-bit down-counter timer with APB register access
`timescale 1ns/10ps
`default_nettype none
module pdct_timer (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_option_byte,
  input wire logic i_timer_pin,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pdct_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [pdct_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [pdct_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_zero_request
);
  logic [7:0] option_byte;
  logic opt_loaded;
  logic option_mode_select;
  pdct_pkg::pdct_cfg_t cfg;
  pdct_pkg::pdct_cfg_t eff_cfg;
  logic count_zero_request_flag;
  logic zero_request_mask;
  logic [pdct_pkg::CNT_W-1:0] timer_count_value;
  logic [pdct_pkg::PRE_W-1:0] prescaler;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic pin_rise;
  logic pre_in;
  logic tap;
  logic [pdct_pkg::PRE_W-1:0] tap_mask;
  logic acc;
  logic wr_ctl;
  logic wr_cnt;
  logic addr_ok;
  logic prescaler_clear_strobe;
  logic [7:0] ctl_read;
  logic [pdct_pkg::CNT_W-1:0] next_count;

  // Option byte is caught on the first clock after reset release
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      option_byte <= 8'hff;
      opt_loaded <= 1'b0;
    end else if (!opt_loaded) begin
      option_byte <= i_option_byte;
      opt_loaded <= 1'b1;
    end
  end

  assign option_mode_select = option_byte[pdct_pkg::BIT_OPT_MODE];

  // APB decode; both registers sit in byte lane 0
  assign addr_ok = (i_paddr == pdct_pkg::OFS_CONTROL) || (i_paddr == pdct_pkg::OFS_COUNT);
  assign acc = i_psel && i_penable;
  assign wr_ctl = acc && i_pwrite && i_pstrb[0] && (i_paddr == pdct_pkg::OFS_CONTROL);
  assign wr_cnt = acc && i_pwrite && i_pstrb[0] && (i_paddr == pdct_pkg::OFS_COUNT);
  assign o_pready = 1'b1;

  // Prescaler clear only acts in software mode
  assign prescaler_clear_strobe = wr_ctl && !option_mode_select
    && i_pwdata[pdct_pkg::BIT_PSC_CLR];

  // Configuration bits: loaded from option byte, then software-writable in software mode
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg <= '1;
    end else if (!opt_loaded) begin
      cfg.clock_source_select <= i_option_byte[pdct_pkg::BIT_SRC_SEL];
      cfg.input_pin_enable <= i_option_byte[pdct_pkg::BIT_PIN_EN];
      cfg.prescale_select <= i_option_byte[pdct_pkg::BIT_PS_LSB +: pdct_pkg::PS_W];
    end else if (wr_ctl && !option_mode_select) begin
      cfg.clock_source_select <= i_pwdata[pdct_pkg::BIT_SRC_SEL];
      cfg.input_pin_enable <= i_pwdata[pdct_pkg::BIT_PIN_EN];
      cfg.prescale_select <= i_pwdata[pdct_pkg::BIT_PS_LSB +: pdct_pkg::PS_W];
    end
  end

  // Option mode: fixed source and ratio from the option byte, pin enable forced on
  always_comb begin
    eff_cfg = cfg;
    if (option_mode_select) begin
      eff_cfg.clock_source_select = option_byte[pdct_pkg::BIT_SRC_SEL];
      eff_cfg.input_pin_enable = 1'b1;
      eff_cfg.prescale_select = option_byte[pdct_pkg::BIT_PS_LSB +: pdct_pkg::PS_W];
    end
  end

  // Pin synchroniser; edge stage makes the third cycle
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
      pin_rise <= 1'b0;
    end else begin
      pin_meta <= i_timer_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      pin_rise <= pin_sync && !pin_prev;
    end
  end

  // Prescaler input pulse per source mode
  always_comb begin
    unique case (pdct_pkg::pdct_src_t'({eff_cfg.clock_source_select,
                                        eff_cfg.input_pin_enable}))
      pdct_pkg::PDCT_SRC_INTERNAL: pre_in = 1'b1;
      pdct_pkg::PDCT_SRC_GATED: pre_in = pin_prev;
      pdct_pkg::PDCT_SRC_OFF: pre_in = 1'b0;
      pdct_pkg::PDCT_SRC_EXTERNAL: pre_in = pin_rise;
    endcase
  end

  // Tap n fires when the low n prescaler bits are all zero: divide by 2^n
  assign tap_mask = pdct_pkg::PRE_W'((8'h01 << eff_cfg.prescale_select) - 8'h01);
  assign tap = pre_in && ((prescaler & tap_mask) == '0)
    && !prescaler_clear_strobe;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prescaler <= pdct_pkg::PRE_RESET;
    end else if (prescaler_clear_strobe) begin
      prescaler <= pdct_pkg::PRE_CLEAR;
    end else if (pre_in) begin
      prescaler <= prescaler - 7'h01;
    end
  end

  // Counter: a write loads, otherwise each tap decrements with wrap
  always_comb begin
    next_count = timer_count_value;
    if (wr_cnt) begin
      next_count = i_pwdata[pdct_pkg::CNT_W-1:0];
    end else if (tap) begin
      next_count = timer_count_value - 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      timer_count_value <= pdct_pkg::CNT_RESET;
    end else begin
      timer_count_value <= next_count;
    end
  end

  // Request flag: a decrement to zero wins over a control register write; a count write blocks it
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_zero_request_flag <= pdct_pkg::REQ_FLAG_RESET;
    end else if (!wr_cnt && tap && timer_count_value == 8'h01) begin
      count_zero_request_flag <= 1'b1;
    end else if (wr_ctl) begin
      count_zero_request_flag <= i_pwdata[pdct_pkg::BIT_REQ_FLAG];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zero_request_mask <= pdct_pkg::REQ_MASK_RESET;
    end else if (wr_ctl) begin
      zero_request_mask <= i_pwdata[pdct_pkg::BIT_REQ_MASK];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_zero_request <= 1'b0;
    end else begin
      o_zero_request <= count_zero_request_flag && !zero_request_mask;
    end
  end

  // Control read image; bit 3 always reads zero
  always_comb begin
    ctl_read = 8'h00;
    ctl_read[pdct_pkg::BIT_REQ_FLAG] = count_zero_request_flag;
    ctl_read[pdct_pkg::BIT_REQ_MASK] = zero_request_mask;
    if (option_mode_select) begin
      ctl_read[pdct_pkg::BIT_SRC_SEL] = 1'b1;
      ctl_read[pdct_pkg::BIT_PIN_EN] = 1'b1;
      ctl_read[pdct_pkg::BIT_PS_LSB +: pdct_pkg::PS_W] = 3'h7;
    end else begin
      ctl_read[pdct_pkg::BIT_SRC_SEL] = cfg.clock_source_select;
      ctl_read[pdct_pkg::BIT_PIN_EN] = cfg.input_pin_enable;
      ctl_read[pdct_pkg::BIT_PS_LSB +: pdct_pkg::PS_W] = cfg.prescale_select;
    end
  end

  // Read data and error are registered in the setup cycle
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_pslverr <= !addr_ok;
      if (i_pwrite || !addr_ok) begin
        o_prdata <= 32'h0000_0000;
      end else if (i_paddr == pdct_pkg::OFS_CONTROL) begin
        o_prdata <= {24'h00_0000, ctl_read};
      end else begin
        o_prdata <= {24'h00_0000, timer_count_value};
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/pdct_timer_props.sv
// Port checker for the prescaled down-counter timer
`timescale 1ns/10ps
`default_nettype none
module pdct_timer_props (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic [7:0] i_option_byte,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pdct_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [pdct_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [pdct_pkg::DATA_W-1:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_zero_request
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic acc, wr_c, wr_n, rd_c, rd_n, mapped;
  assign acc = i_psel && i_penable;
  assign mapped = i_paddr == pdct_pkg::OFS_CONTROL || i_paddr == pdct_pkg::OFS_COUNT;
  assign wr_c = acc && i_pwrite && i_pstrb[0] && i_paddr == pdct_pkg::OFS_CONTROL;
  assign wr_n = acc && i_pwrite && i_pstrb[0] && i_paddr == pdct_pkg::OFS_COUNT;
  assign rd_c = acc && !i_pwrite && i_paddr == pdct_pkg::OFS_CONTROL;
  assign rd_n = i_psel && !i_penable && !i_pwrite && i_paddr == pdct_pkg::OFS_COUNT;
  AST_RST_QUIET: assert property ($rose(i_arst_n) |-> !o_zero_request [*2])
    else $error("request after reset");
  AST_CTRL_B3: assert property (rd_c |-> !o_prdata[3] && o_prdata[31:8] == 24'h0)
    else $error("control clear bit not zero");
  AST_OPT_ONES: assert property (rd_c && i_option_byte[6] |-> &o_prdata[5:4] && &o_prdata[2:0])
    else $error("option mode bits not one");
  AST_UNMAPPED: assert property (acc && !mapped |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && mapped |-> !o_pslverr)
    else $error("mapped access refused");
  AST_REQ_HOLD: assert property ($fell(o_zero_request) |-> $past(wr_c, 2))
    else $error("request dropped without write");
  AST_MASK: assert property (wr_c && i_pwdata[6] |=> ##1 !o_zero_request)
    else $error("masked request visible");
  AST_LOAD: assert property (wr_n ##1 rd_n |=> o_prdata[7:0] == $past(i_pwdata[7:0], 2))
    else $error("count load not read back");
  AST_READY: assert property (acc |-> o_pready)
    else $error("access stalled");
  cover property ($rose(o_zero_request));
  cover property (acc && !mapped);
  cover property (wr_c && i_pwdata[3]);
endmodule
bind pdct_timer pdct_timer_props u_props (.*);
`default_nettype wire

//--- tb/pdct_pin_model.sv
// Timer pin source emitting counted pulses
`timescale 1ns/10ps
`default_nettype none
module pdct_pin_model (
  input wire logic i_clk_sys,
  output logic o_pin
);
  initial o_pin = 1'b0;
  // High two cycles, low two: each level is seen so the pin logic re-arms
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk_sys) o_pin <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      o_pin <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/pdct_timer_bench.sv
// Self-checking bench for the prescaled down-counter timer
`timescale 1ns/10ps
`default_nettype none
module pdct_timer_bench;
  logic i_clk_sys = 1'b0, i_arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] opt = 8'h20, paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, zreq, pin, err;
  int bad_count = 0, n_tests = 0, n;
  always #5 i_clk_sys = ~i_clk_sys;
  pdct_pin_model PIN (.i_clk_sys(i_clk_sys), .o_pin(pin));
  pdct_timer DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_option_byte(opt),
    .i_timer_pin(pin), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_zero_request(zreq));
  task automatic end_of_test;
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request stays up at the end so the next transfer may follow at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge i_clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    cmp(nm, exp, rd);
  endtask
  task automatic chk_req(input logic exp);
    repeat (4) @(negedge i_clk_sys);
    cmp("request", {31'h0, exp}, {31'h0, zreq});
    @(posedge i_clk_sys);
  endtask
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    rchk("control", 8'h00, 32'h60);
    rchk("count", 8'h04, 32'hff);
    rchk("unmapped", 8'h08, 32'h0);
    cmp("slverr", 32'h1, {31'h0, err});
    apb(1'b1, 8'h04, 8'h03);
    rchk("load", 8'h04, 32'h03);
    apb(1'b1, 8'h00, 8'h08);
    idle();
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (zreq !== 1'b1 && n < 300);
    cmp("zero delay", 32'd4, n);
    @(posedge i_clk_sys);
    rchk("flag", 8'h00, 32'h80);
    rchk("wrapped", 8'h04, 32'hfc);
    apb(1'b1, 8'h00, 8'h60);
    idle();
    chk_req(1'b0);
    apb(1'b1, 8'h00, 8'h39);
    apb(1'b1, 8'h04, 8'h02);
    idle();
    PIN.pulses(3);
    chk_req(1'b0);
    rchk("edges", 8'h04, 32'h01);
    idle();
    PIN.pulses(1);
    chk_req(1'b1);
    apb(1'b1, 8'h04, 8'h10);
    apb(1'b1, 8'h00, 8'h58);
    idle();
    PIN.pulses(2);
    chk_req(1'b0);
    rchk("gated", 8'h04, 32'h0c);
    idle();
    i_arst_n <= 1'b0;
    opt <= 8'h43;
    repeat (5) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    rchk("option", 8'h00, 32'h77);
    apb(1'b1, 8'h00, 8'h00);
    rchk("option write", 8'h00, 32'h37);
    idle();
    end_of_test();
  end
endmodule
`default_nettype wire
